// ==== common/clk_out_pkg.sv ====
/*
 * Shared constants and types for the output clock routing control block.
 * Assumes an APB master with 32-bit data and word-aligned registers.
 */
`default_nettype none
package clk_out_pkg;
   localparam int NUM_DIV = 5;
   localparam int NUM_OUT = 10;
   localparam int NUM_STAT = 4;
   localparam int NUM_PAGE = 4;
   localparam int SEL_W = 3;
   localparam int SKEW_W = 16;
   localparam int STORE_MAX_WRITES = 2;

   // Byte addresses: 12-bit page/offset address, word per register.
   localparam logic [11:0] A_PAGE_SEL = 12'h004;
   localparam logic [11:0] A_STATUS = 12'h008;
   localparam logic [11:0] A_IRQ_MASK = 12'h00C;
   localparam logic [11:0] A_CONTROL = 12'h010;
   localparam logic [11:0] A_STORE_CTL = 12'h014;
   localparam logic [11:0] A_OUT_BASE = 12'h100;
   localparam logic [11:0] A_SKEW_BASE = 12'h200;

   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [3:0] MASK_RESET = 4'hF;
   localparam logic [15:0] SKEW_RESET = 16'h0000;

   // Control bits.
   localparam int CTL_HARD_RST = 0;
   localparam int CTL_SYNC = 1;
   localparam int CTL_ZDM = 2;
   localparam int CTL_KEEP_ON_REF_LOSS = 3;
   localparam int CTL_SPI_3WIRE = 4;

   typedef enum logic [1:0] {
      FMT_DIFF_NORMAL, FMT_DIFF_HIGH, FMT_SINGLE
   } out_fmt_e;
   typedef enum logic [1:0] {DIS_LOW, DIS_HIGH, DIS_HIZ} dis_state_e;
   typedef enum logic [1:0] {
      DRIVE_ONE, DRIVE_TWO, DRIVE_THREE
   } drive_e;

   // Per-output configuration word, layout of register A_OUT_BASE+4*n.
   typedef struct packed {
      logic       sync_dis;
      logic       invert;
      logic       complement;
      logic [1:0] dis_state;
      logic [1:0] drive;
      logic [2:0] swing;
      logic [1:0] fmt;
      logic       enable;
      logic [2:0] div_sel;
   } out_cfg_s;
   localparam int OUT_CFG_W = $bits(out_cfg_s);
   localparam out_cfg_s OUT_CFG_RESET = '0;

   // Pad-facing output view.
   typedef struct packed {
      logic p;
      logic n;
      logic oe_p;
      logic oe_n;
   } pad_s;
endpackage
`default_nettype wire

// ==== verif/store_model.sv ====
/* Config store model: answers a load request with output words, then
   skew words, one per cycle, and ends with a one-cycle done pulse.
   Assumes the requester holds its request until done has been seen. */
`default_nettype none
module store_model #(
   parameter int NOUT = 10,
   parameter int NDIV = 5,
   parameter int LAG  = 3
) (
   // Clock
   input  wire logic        pclk,
   // Load handshake
   input  wire logic        store_load_req,
   output logic             store_load_valid,
   output logic [4:0]       store_load_idx,
   output logic [31:0]      store_load_data,
   output logic             store_load_done
);
   timeunit 1ns;
   timeprecision 1ps;
   int k;
   initial begin
      store_load_valid = 1'b0;
      store_load_idx = 5'h1F;
      store_load_data = 32'hA5A5A5A5;
      store_load_done = 1'b0;
   end
   // A slow store is modelled by LAG idle cycles before the first word.
   // After the last word the index and data lines flip so that stale values never pass.
   always begin
      @(posedge pclk iff store_load_req === 1'b1);
      repeat (LAG) @(posedge pclk);
      for (k = 0; k < NOUT + NDIV; k++) begin
         store_load_valid <= 1'b1;
         store_load_idx <= (k < NOUT) ? 5'(k) : 5'(16 + k - NOUT);
         store_load_data <= (k < NOUT) ? 32'h28 + 32'(k % NDIV)
                                       : 32'h100 + 32'(k - NOUT);
         @(posedge pclk);
      end
      store_load_valid <= 1'b0;
      store_load_idx <= ~store_load_idx;
      store_load_data <= ~store_load_data;
      store_load_done <= 1'b1;
      @(posedge pclk);
      store_load_done <= 1'b0;
      @(posedge pclk iff store_load_req !== 1'b1);
   end
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
/* Self-checking bench for clk_out_ctrl with a register-state model.
   Assumes store_model answers the boot and hard-reset loads. */
`default_nettype none
module tb;
   import clk_out_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, reference_loss_flag = 1'b0, out_gate_pin = 1'b0;
   logic host_port_i2c_sel = 1'b0, err;
   logic [11:0]           paddr = 12'h000;
   logic [31:0]           pwdata = 32'h0, prdata, r, seed = 32'hFEDE5070;
   logic [3:0]            flags = 4'h0;
   logic [NUM_DIV-1:0]    div_clk = '0;
   pad_s [NUM_OUT-1:0]    output_pin_pair;
   logic [NUM_OUT*3-1:0]  out_swing;
   logic [NUM_OUT*2-1:0]  out_drive, out_fmt;
   logic [NUM_DIV*16-1:0] div_skew;
   logic pready, pslverr, irq_out_pin, ready, div_realign, internal_fb_open;
   logic use_external_feedback_input, input_switch_inhibit, host_spi_3wire;
   logic store_load_req, store_load_valid, store_load_done, store_write_req;
   logic [4:0]            store_load_idx;
   logic [31:0]           store_load_data;
   int                    n_fail = 0, check_count = 0, n_wr = 0, n_ra = 0;
   int                    cfg_m [NUM_OUT];
   out_cfg_s              c;

   clk_out_ctrl u_clk_out_ctrl (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr,
      .signal_loss_flag(flags[0]), .freq_out_of_range_flag(flags[1]),
      .lock_lost_flag(flags[2]), .holdover_flag(flags[3]),
      .reference_loss_flag, .irq_out_pin, .div_clk, .out_gate_pin,
      .output_pin_pair, .out_swing, .out_drive, .out_fmt, .div_skew,
      .div_realign, .internal_fb_open, .use_external_feedback_input,
      .input_switch_inhibit, .host_port_i2c_sel, .host_spi_3wire,
      .store_load_req, .store_load_valid, .store_load_idx, .store_load_data,
      .store_load_done, .store_write_req, .ready);
   store_model u_store_model (.pclk, .store_load_req, .store_load_valid,
      .store_load_idx, .store_load_data, .store_load_done);

   initial begin
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      n_wr <= n_wr + int'(store_write_req === 1'b1);
      n_ra <= n_ra + int'(div_realign === 1'b1);
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   // Every master signal moves by NBA just after a rising edge.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic set_out(input int n, input out_cfg_s v);
      cfg_m[n] = int'(v);
      apb(1'b1, A_OUT_BASE + 12'(4 * n), 32'(v));
   endtask
   // High-impedance pins carry no defined level, so only enables count.
   task automatic chk_pad(input int n, input logic off);
      out_cfg_s m;
      logic [3:0] e;
      m = out_cfg_s'(cfg_m[n][15:0]);
      e[3] = div_clk[m.div_sel] ^ m.invert;
      e[2:0] = {e[3] ^ m.complement, 2'b11};
      if (off || !m.enable)
         e = (m.dis_state == 2'(DIS_HIZ)) ? 4'h0 : {{2{m.dis_state[0]}}, 2'b11};
      chk(32'(e == 4'h0 ? {2'b00, output_pin_pair[n][1:0]}
                        : output_pin_pair[n]), 32'(e));
   endtask
   task automatic wait_ready();
      int k;
      k = 0;
      while (store_load_req !== 1'b1 && k++ < 20) cyc(1);
      while (ready !== 1'b1 && k++ < 300) cyc(1);
      chk(32'(ready), 32'h1);
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      $display("ERROR at %0t watchdog ran out", $time);
      summarize();
   end

   initial begin
      int n, s, k;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      wait_ready();
      for (n = 0; n < NUM_OUT; n++) begin
         cfg_m[n] = 32'h28 + n % NUM_DIV;
         apb(1'b0, A_OUT_BASE + 12'(4 * n), 32'h0);
         chk(r, 32'(cfg_m[n]));
      end
      for (n = 0; n < NUM_DIV; n++)
         chk(32'(div_skew[16*n +: 16]), 32'h100 + 32'(n));
      apb(1'b0, A_PAGE_SEL, 32'h0);
      chk(r, 32'(PAGE_RESET));
      apb(1'b0, A_IRQ_MASK, 32'h0);
      chk(r, 32'(MASK_RESET));
      $display("boot test done");
      apb(1'b1, A_IRQ_MASK, 32'h0);
      for (n = 0; n < NUM_STAT; n++) begin
         flags[n] <= 1'b1;
         apb(1'b0, A_STATUS, 32'h0);
         chk(r, {24'h0, flags, 4'(1 << n)});
         chk(32'(irq_out_pin), 32'h1);
         apb(1'b1, A_IRQ_MASK, 32'(1 << n));
         chk(32'(irq_out_pin), 32'h0);
         apb(1'b1, A_IRQ_MASK, 32'h0);
         apb(1'b1, A_STATUS, 32'(1 << n));
         chk(32'(irq_out_pin), 32'h0);
         flags[n] <= 1'b0;
         cyc(4);
         apb(1'b1, A_STATUS, 32'(1 << n));
      end
      $display("status test done");
      for (n = 0; n < NUM_OUT; n++) begin
         c = '0;
         c.div_sel = 3'(rnd() % NUM_DIV);
         c.enable = 1'b1;
         c.fmt = (n < 3) ? 2'(n) : 2'(FMT_SINGLE);
         c.swing = 3'(1 + rnd() % 7);
         c.drive = 2'(n % 3);
         c.complement = 1'(rnd() % 2);
         c.invert = 1'(rnd() % 2);
         set_out(n, c);
         chk(32'({out_swing[3*n +: 3], out_drive[2*n +: 2], out_fmt[2*n +: 2]}),
             32'({c.swing, c.drive, c.fmt}));
         for (k = 0; k < 4 && n > 2; k++) begin
            @(posedge pclk);
            div_clk <= NUM_DIV'(rnd());
            #1;
            chk_pad(n, 1'b0);
         end
      end
      $display("crosspoint test done");
      div_clk <= '1;
      for (s = 0; s < 3; s++) begin
         c.dis_state = 2'(s);
         set_out(9, c);
         out_gate_pin <= 1'b1;
         cyc(4);
         chk_pad(9, 1'b1);
         out_gate_pin <= 1'b0;
         cyc(4);
         chk_pad(9, 1'b0);
      end
      c.dis_state = 2'(DIS_LOW);
      c.invert = 1'b0;
      for (s = 0; s < 2; s++) begin
         c.sync_dis = s[0];
         c.enable = 1'b1;
         set_out(9, c);
         cyc(2);
         c.enable = 1'b0;
         set_out(9, c);
         // The enable register lands at the write edge; on_q follows one
         // edge later, so look after that edge with the source still high.
         cyc(1);
         chk(32'(output_pin_pair[9].p), 32'(s));
         div_clk <= '0;
         cyc(2);
         div_clk <= '1;
         cyc(2);
         chk_pad(9, 1'b0);
      end
      c.enable = 1'b1;
      c.sync_dis = 1'b0;
      set_out(9, c);
      reference_loss_flag <= 1'b1;
      cyc(4);
      chk_pad(9, 1'b1);
      apb(1'b1, A_CONTROL, 32'h8);
      cyc(2);
      chk_pad(9, 1'b0);
      reference_loss_flag <= 1'b0;
      $display("disable test done");
      apb(1'b1, A_CONTROL, 32'h14);
      chk(32'({internal_fb_open, use_external_feedback_input,
               input_switch_inhibit, host_spi_3wire}), 32'hF);
      host_port_i2c_sel <= 1'b1;
      cyc(1);
      chk(32'(host_spi_3wire), 32'h0);
      k = n_ra;
      apb(1'b1, A_CONTROL, 32'h2);
      cyc(4);
      chk(32'({n_ra > k, ready}), 32'h3);
      apb(1'b0, 12'h0FC, 32'h0);
      chk({r[30:0], err}, 32'h1);
      k = n_wr;
      repeat (3) apb(1'b1, A_STORE_CTL, 32'h1);
      cyc(2);
      chk(32'(n_wr - k), 32'h2);
      apb(1'b0, A_STORE_CTL, 32'h0);
      chk(r & 32'h6, 32'h4);
      apb(1'b1, A_SKEW_BASE, 32'h1234);
      chk(32'(div_skew[15:0]), 32'h1234);
      apb(1'b1, A_CONTROL, 32'h1);
      wait_ready();
      chk(32'(div_skew[15:0]), 32'h100);
      $display("control test done");
      summarize();
   end
endmodule
`default_nettype wire

// ==== verilog/clk_out_ctrl.sv ====
/*
 * Output clock routing control: status interrupt, divider-to-output
 * crosspoint, per-output format, gating, disable state, skew registers,
 * zero-delay and divider realignment control, config store loading.
 * Assumes divider clocks are sampled as data in pclk and that the
 * config store answers a load request with one word per cycle.
 */
//
// Overview of operation
// - Interrupt rises when signal-loss, range, lock or holdover flag changes.
// - Each status indicator has its own mask blocking the interrupt.
// - Interrupt holds until host clears the causing sticky bit.
// - Each indicator has a live bit and a sticky bit.
// - Any of ten outputs selects any one of five dividers.
// - Crosspoint setting is loaded from the config store at power-up.
// - Output picks normal swing, high swing or single-ended; swing 1..7.
// - Single-ended output has a three-setting drive strength field.
// - Single-ended pins in phase by default; complement and invert bits.
// - Gating pin high disables all outputs; low enables them.
// - Each gated-on output can still be disabled by its own bit.
// - Reference loss disables outputs unless the keep option is set.
// - Disabled level is low, high or high impedance per output.
// - Synchronous disable waits for the current high phase to end.
// - Without synchronous disable the output stops at once.
// - Each divider path has a skew register; zero means aligned.
// - Skew returns to default on reset, hard reset or store load.
// - Zero-delay mode opens internal feedback and stops input switching.
// - Dividers realign on power-up, reset pin or hard reset.
// - Sync bit realigns dividers without resetting anything else.
// - Defaults load from the config store before normal operation.
// - Config store accepts at most two writes; newest replaces old.
// - Port select pin picks I2C or SPI; SPI in 3- or 4-wire.
// - Page register at offset 0x01 on every page, reset to page 0.
`default_nettype none
module clk_out_ctrl #(
   parameter int NDIV = clk_out_pkg::NUM_DIV,
   parameter int NOUT = clk_out_pkg::NUM_OUT
) (
   // APB slave
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [11:0]               paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   // Status indicators: signal loss, range, lock lost, holdover
   input  wire logic                      signal_loss_flag,
   input  wire logic                      freq_out_of_range_flag,
   input  wire logic                      lock_lost_flag,
   input  wire logic                      holdover_flag,
   input  wire logic                      reference_loss_flag,
   output logic                           irq_out_pin,
   // Divider clocks and output pads
   input  wire logic [NDIV-1:0]           div_clk,
   input  wire logic                      out_gate_pin,
   output clk_out_pkg::pad_s [NOUT-1:0]   output_pin_pair,
   output logic      [NOUT*3-1:0]         out_swing,
   output logic      [NOUT*2-1:0]         out_drive,
   output logic      [NOUT*2-1:0]         out_fmt,
   // Divider and loop control
   output logic      [NDIV*16-1:0]        div_skew,
   output logic                           div_realign,
   output logic                           internal_fb_open,
   output logic                           use_external_feedback_input,
   output logic                           input_switch_inhibit,
   // Host port selection
   input  wire logic                      host_port_i2c_sel,
   output logic                           host_spi_3wire,
   // Config store
   output logic                           store_load_req,
   input  wire logic                      store_load_valid,
   input  wire logic [4:0]                store_load_idx,
   input  wire logic [31:0]               store_load_data,
   input  wire logic                      store_load_done,
   output logic                           store_write_req,
   output logic                           ready
);
   import clk_out_pkg::*;

   initial begin
      if (NDIV < 1 || NDIV > 8 || NOUT < 1 || NOUT > 16)
         $error("clk_out_ctrl: unsupported divider or output count");
   end

   typedef enum logic [1:0] {ST_RESET, ST_LOAD, ST_RUN} boot_e;
   boot_e boot_q;

   logic [7:0]         page_q;
   logic [3:0]         mask_q, sticky_q, live_q;
   logic [4:0]         ctl_q;
   logic [1:0]         writes_q;
   logic               align_q;
   out_cfg_s           cfg_q [NOUT];
   logic [SKEW_W-1:0]  skew_q [NDIV];

   wire logic [3:0] live_now = {holdover_flag, lock_lost_flag,
                                freq_out_of_range_flag, signal_loss_flag};
   wire logic acc = psel & penable;
   wire logic wr = acc & pwrite;
   wire logic is_page = paddr == A_PAGE_SEL;
   wire logic is_stat = paddr == A_STATUS;
   wire logic is_mask = paddr == A_IRQ_MASK;
   wire logic is_ctl = paddr == A_CONTROL;
   wire logic is_store = paddr == A_STORE_CTL;
   wire logic [7:0] oidx = 8'(paddr[9:2] - 8'(A_OUT_BASE >> 2));
   wire logic [7:0] sidx = 8'(paddr[9:2] - 8'(A_SKEW_BASE >> 2));
   wire logic is_out = paddr[11:8] == A_OUT_BASE[11:8] && paddr[1:0] == 2'b00
                       && oidx < 8'(NOUT);
   wire logic is_skew = paddr[11:8] == A_SKEW_BASE[11:8]
                        && paddr[1:0] == 2'b00 && sidx < 8'(NDIV);
   wire logic mapped = is_page | is_stat | is_mask | is_ctl | is_store
                       | is_out | is_skew;
   wire logic hard_rst = wr & is_ctl & pwdata[CTL_HARD_RST];
   wire logic store_wr = wr & is_store & pwdata[0];
   wire logic [3:0] change = live_now ^ live_q;
   wire logic ref_kill = reference_loss_flag & ~ctl_q[CTL_KEEP_ON_REF_LOSS];

   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;
   assign irq_out_pin = |(sticky_q & ~mask_q);
   assign ready = boot_q == ST_RUN;
   assign store_load_req = boot_q == ST_LOAD;
   assign store_write_req = store_wr & (writes_q < 2'(STORE_MAX_WRITES));
   assign div_realign = align_q;
   assign internal_fb_open = ctl_q[CTL_ZDM];
   assign use_external_feedback_input = ctl_q[CTL_ZDM];
   assign input_switch_inhibit = ctl_q[CTL_ZDM];
   assign host_spi_3wire = ~host_port_i2c_sel
                           & ctl_q[CTL_SPI_3WIRE];

   always_comb begin
      prdata = '0;
      if (acc & ~pwrite) begin
         if (is_page) prdata[7:0] = page_q;
         else if (is_stat) prdata[7:0] = {live_q, sticky_q};
         else if (is_mask) prdata[3:0] = mask_q;
         else if (is_ctl) prdata[4:0] = ctl_q;
         else if (is_store) prdata[2:1] = writes_q;
         else if (is_out) prdata[OUT_CFG_W-1:0] = cfg_q[oidx[3:0]];
         else if (is_skew) prdata[SKEW_W-1:0] = skew_q[sidx[2:0]];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_q <= ST_RESET;
         page_q <= PAGE_RESET;
         mask_q <= MASK_RESET;
         ctl_q <= '0;
         writes_q <= '0;
         align_q <= 1'b1;
      end else begin
         align_q <= hard_rst | (boot_q != ST_RUN)
                    | (wr & is_ctl & pwdata[CTL_SYNC]);
         case (boot_q)
            ST_RESET: boot_q <= ST_LOAD;
            ST_LOAD: if (store_load_done) boot_q <= ST_RUN;
            ST_RUN: if (hard_rst) boot_q <= ST_LOAD;
            default: boot_q <= ST_RESET;
         endcase
         if (hard_rst) begin
            page_q <= PAGE_RESET;
            mask_q <= MASK_RESET;
            ctl_q <= '0;
         end else begin
            if (wr & is_page) page_q <= pwdata[7:0];
            if (wr & is_mask) mask_q <= pwdata[3:0];
            if (wr & is_ctl) ctl_q <= {pwdata[4:2], 2'b00};
         end
         if (store_write_req)
            writes_q <= 2'(writes_q + 2'd1);
      end
   end

   // Live tracks inputs; sticky set wins over a same-cycle clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         live_q <= '0;
         sticky_q <= '0;
      end else begin
         live_q <= live_now;
         sticky_q <= (sticky_q & ~((wr & is_stat) ? pwdata[3:0] : 4'h0))
                     | change;
      end
   end

   // Skew registers reload defaults on reset and hard reset; loaded values
   // at indices 16.. come from the store.
   genvar d;
   generate
      for (d = 0; d < NDIV; d++) begin : g_div
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn)
               skew_q[d] <= SKEW_RESET;
            else if (hard_rst)
               skew_q[d] <= SKEW_RESET;
            else if (store_load_valid && store_load_idx == 5'(16 + d))
               skew_q[d] <= store_load_data[SKEW_W-1:0];
            else if (wr && is_skew && sidx == 8'(d))
               skew_q[d] <= pwdata[SKEW_W-1:0];
         end
         assign div_skew[d*16 +: 16] = 16'(skew_q[d]);
      end
   endgenerate

   genvar o;
   generate
      for (o = 0; o < NOUT; o++) begin : g_out
         logic gate_s1_q, gate_s2_q, on_q, src_d1_q;
         logic [SEL_W-1:0] sel;
         logic src, want_on, fall, se;
         assign sel = cfg_q[o].div_sel < SEL_W'(NDIV)
                      ? cfg_q[o].div_sel : '0;
         assign src = div_clk[sel];
         assign want_on = ~gate_s2_q & cfg_q[o].enable & ~ref_kill
                          & ready;
         assign fall = src_d1_q & ~src;
         assign se = cfg_q[o].fmt == 2'(FMT_SINGLE);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cfg_q[o] <= OUT_CFG_RESET;
               gate_s1_q <= 1'b1;
               gate_s2_q <= 1'b1;
               on_q <= 1'b0;
               src_d1_q <= 1'b0;
            end else begin
               gate_s1_q <= out_gate_pin;
               gate_s2_q <= gate_s1_q;
               src_d1_q <= src;
               if (want_on)
                  on_q <= 1'b1;
               else if (!cfg_q[o].sync_dis || fall || !src)
                  on_q <= 1'b0;
               if (store_load_valid && store_load_idx == 5'(o))
                  cfg_q[o] <= out_cfg_s'(store_load_data[OUT_CFG_W-1:0]);
               else if (wr && is_out && oidx == 8'(o))
                  cfg_q[o] <= out_cfg_s'(pwdata[OUT_CFG_W-1:0]);
            end
         end
         // Clock passes combinationally so edges are not delayed a cycle.
         always_comb begin
            output_pin_pair[o].p = on_q ? src ^ cfg_q[o].invert
                                   : cfg_q[o].dis_state == 2'(DIS_HIGH);
            output_pin_pair[o].n = on_q ? (se ? src ^ cfg_q[o].invert
                                           ^ cfg_q[o].complement : ~src)
                                   : cfg_q[o].dis_state == 2'(DIS_HIGH);
            output_pin_pair[o].oe_p = on_q
                                      | (cfg_q[o].dis_state != 2'(DIS_HIZ));
            output_pin_pair[o].oe_n = output_pin_pair[o].oe_p;
         end
         assign out_swing[o*3 +: 3] = cfg_q[o].swing;
         assign out_drive[o*2 +: 2] = cfg_q[o].drive;
         assign out_fmt[o*2 +: 2] = cfg_q[o].fmt;

         a_sync_disable_wait: assert property (@(posedge pclk)
            disable iff (!presetn)
            on_q && !want_on && cfg_q[o].sync_dis && src && !fall
            |=> on_q)
            else $error("sync disable cut a high phase");
         a_async_disable_now: assert property (@(posedge pclk)
            disable iff (!presetn)
            !want_on && !cfg_q[o].sync_dis |=> !on_q)
            else $error("immediate disable did not stop output");
         a_gate_pin_off: assert property (@(posedge pclk)
            disable iff (!presetn)
            out_gate_pin [*3] |-> !want_on)
            else $error("gate pin high did not disable output");
      end
   endgenerate

   sequence s_change;
      |(live_now ^ live_q);
   endsequence
   a_irq_on_change: assert property (@(posedge pclk)
      disable iff (!presetn)
      s_change ##0 (|((live_now ^ live_q) & ~mask_q)) |=> irq_out_pin)
      else $error("unmasked change did not raise interrupt");
   a_irq_masked: assert property (@(posedge pclk)
      disable iff (!presetn)
      (sticky_q & ~mask_q) == 4'h0 |-> !irq_out_pin)
      else $error("masked indicator raised interrupt");
   a_sticky_holds: assert property (@(posedge pclk)
      disable iff (!presetn)
      irq_out_pin && !(wr && is_stat) && !hard_rst
      && !(wr && is_mask) |=> irq_out_pin)
      else $error("interrupt dropped without a clear");
   a_page_reset: assert property (@(posedge pclk)
      disable iff (!presetn)
      hard_rst |=> page_q == PAGE_RESET)
      else $error("page not returned to zero");
   a_store_limit: assert property (@(posedge pclk)
      disable iff (!presetn)
      writes_q == 2'(STORE_MAX_WRITES) |-> !store_write_req)
      else $error("third store write accepted");
   a_zdm_outputs: assert property (@(posedge pclk)
      disable iff (!presetn)
      wr && is_ctl && pwdata[CTL_ZDM] && !pwdata[CTL_HARD_RST]
      |=> internal_fb_open && input_switch_inhibit)
      else $error("zero-delay mode not applied");
   a_realign_sync: assert property (@(posedge pclk)
      disable iff (!presetn)
      wr && is_ctl && pwdata[CTL_SYNC] |=> div_realign && $stable(mask_q))
      else $error("sync bit did not realign dividers");
endmodule
`default_nettype wire
